/* File: fple_consts.vh */
// Constants for the log-binary exponent unit
`ifndef FPLE_CONSTS_VH
`define FPLE_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define FPLE_OFF_SRC_LO 8'h00
`define FPLE_OFF_SRC_HI 8'h04
`define FPLE_OFF_CFG 8'h08
`define FPLE_OFF_CMD 8'h0C
`define FPLE_OFF_RES_LO 8'h10
`define FPLE_OFF_RES_HI 8'h14
`define FPLE_OFF_STATUS 8'h18
`define FPLE_OFF_INT_CLR 8'h1C
`define FPLE_OFF_INT_EN 8'h20
`define FPLE_OFF_INFO 8'h24

// ****************************************
// Control field positions
// ****************************************
`define FPLE_CFG_DBL 0
`define FPLE_CFG_NORM 1
`define FPLE_CFG_FE_INV 2
`define FPLE_CFG_FE_ZDIV 3
`define FPLE_CFG_FE_UNDER 4
`define FPLE_CFG_FE_INEX 5
`define FPLE_CFG_W 6
`define FPLE_CMD_W 15
`define FPLE_KIND_GREG 2'h0
`define FPLE_KIND_FREG 2'h1
`define FPLE_KIND_FLIT 2'h2

// ****************************************
// Status bit positions
// ****************************************
`define FPLE_ST_DONE 0
`define FPLE_ST_FAULT 1
`define FPLE_ST_RSVD 2
`define FPLE_ST_INV 3
`define FPLE_ST_ZDIV 4
`define FPLE_ST_UNDER 5
`define FPLE_ST_INEX 6
`define FPLE_ST_OPND 7
`define FPLE_ST_W 8

// ****************************************
// Reset values
// ****************************************
`define FPLE_RST_CFG 6'h00
`define FPLE_RST_CMD 15'h0000
`define FPLE_RST_STATUS 8'h00
`define FPLE_RST_WORD 32'h0000_0000

// ****************************************
// Format constants
// ****************************************
`define FPLE_BIAS_S 12'h07F
`define FPLE_BIAS_D 12'h3FF
`define FPLE_DEN_OFF_S 12'h0B2
`define FPLE_DEN_OFF_D 12'h432
`define FPLE_ONE_S 32'h3F80_0000
`define FPLE_ONE_D 64'h3FF0_0000_0000_0000
`define FPLE_PINF_S 32'h7F80_0000
`define FPLE_PINF_D 64'h7FF0_0000_0000_0000
`define FPLE_NINF_S 32'hFF80_0000
`define FPLE_NINF_D 64'hFFF0_0000_0000_0000
`define FPLE_QBIT_S 22
`define FPLE_QBIT_D 51

// ****************************************
// Sequencer states
// ****************************************
`define FPLE_ST_IDLE 1'b0
`define FPLE_ST_EXEC 1'b1

`endif

/* File: fple_unpack.v */
// Source classification and unbiased exponent extraction
`timescale 1ns/1ps
`default_nettype none
`include "fple_consts.vh"

module fple_unpack (
	input wire [63:0] src,
	input wire dbl,
	output wire is_zero,
	output wire is_denorm,
	output wire is_inf,
	output wire is_nan,
	output wire is_snan,
	output wire [11:0] exp_unb
);
	wire [10:0] efld;
	wire [51:0] frac;
	wire e_max;
	reg [5:0] lead;
	integer i;

	// ****************************************
	// Field split
	// ****************************************
	assign efld = dbl ? src[62:52] : {3'h0, src[30:23]};
	assign frac = dbl ? src[51:0] : {src[22:0], 29'h0000_0000};
	assign e_max = dbl ? (efld == 11'h7FF) : (efld == 11'h0FF);
	assign is_zero = (efld == 11'h000) && (frac == 52'h0_0000_0000_0000);
	assign is_denorm = (efld == 11'h000) && (frac != 52'h0_0000_0000_0000);
	assign is_inf = e_max && (frac == 52'h0_0000_0000_0000);
	assign is_nan = e_max && (frac != 52'h0_0000_0000_0000);
	assign is_snan = is_nan && !frac[51];

	// ****************************************
	// Leading one of the fraction
	// ****************************************
	always @* begin
		lead = 6'h00;
		for (i = 0; i < 52; i = i + 1) begin
			if (frac[i])
				lead = i[5:0];
		end
	end

	assign exp_unb = is_denorm ? ({6'h00, lead} - (dbl ? `FPLE_DEN_OFF_D : `FPLE_DEN_OFF_S)) :
		({1'b0, efld} - (dbl ? `FPLE_BIAS_D : `FPLE_BIAS_S));
endmodule
`default_nettype wire

/* File: fple_i2f.v */
// Signed exponent to floating real conversion
`timescale 1ns/1ps
`default_nettype none
`include "fple_consts.vh"

module fple_i2f (
	input wire [11:0] ival,
	input wire dbl,
	output wire [63:0] res,
	output wire inexact,
	output wire underflow
);
	wire neg;
	wire [10:0] mag;
	wire [63:0] sh;
	wire [11:0] e_d;
	wire [11:0] e_s;
	reg [3:0] q;
	integer i;

	assign neg = ival[11];
	assign mag = neg ? (~ival[10:0] + 11'h001) : ival[10:0];

	always @* begin
		q = 4'h0;
		for (i = 0; i < 11; i = i + 1) begin
			if (mag[i])
				q = i[3:0];
		end
	end

	// ****************************************
	// Pack
	// ****************************************
	assign sh = {53'h0, mag} << (6'h34 - {2'h0, q});
	assign e_d = {8'h00, q} + `FPLE_BIAS_D;
	assign e_s = {8'h00, q} + `FPLE_BIAS_S;
	assign res = (mag == 11'h000) ? 64'h0000_0000_0000_0000 :
		dbl ? {neg, e_d[10:0], sh[51:0]} :
		{32'h0000_0000, neg, e_s[7:0], sh[51:29]};
	assign inexact = !dbl && (sh[28:0] != 29'h0000_0000);
	assign underflow = (mag != 11'h000) && ((dbl ? e_d[10:0] : {3'h0, e_s[7:0]}) == 11'h000);
endmodule
`default_nettype wire

/* File: fple_unit.v */
// APB-controlled log-binary exponent datapath
// Notes on behaviour
// - Result is the integral base-2 log, the unbiased exponent, as a real.
// - Denormal sources give the exponent after full normalization.
// - Double form: general register operands must be even, naming a pair.
// - Source from general register, floating register or literal; result to general or floating register.
// - Infinity gives plus infinity, NaN gives NaN, finite gives signed finite.
// - Zero source raises zero-divide instead of an ordinary result.
// - Denormal source with normalizing mode set raises reserved-encoding fault.
// - Underflow flagged when result too small for destination format.
// - Invalid-operation flagged for a signaling NaN source.
// - Inexact flagged when result not exactly representable.
// - Each exception faults only if its own control bit is set.
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "fple_consts.vh"

module fple_unit (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg irq
);
	// ****************************************
	// Registers
	// ****************************************
	reg [31:0] src_lo_r;
	reg [31:0] src_hi_r;
	reg [`FPLE_CFG_W-1:0] cfg_r;
	reg [`FPLE_CMD_W-1:0] cmd_r;
	reg [31:0] res_lo_r;
	reg [31:0] res_hi_r;
	reg [`FPLE_ST_W-1:0] status_r;
	reg [`FPLE_ST_W-1:0] status_nxt;
	reg [`FPLE_ST_W-1:0] int_en_r;
	reg state_r;
	reg state_nxt;

	wire access;
	wire commit;
	wire wr;
	wire start;
	reg [31:0] rd_mux;
	reg bad_addr;
	reg bad_wr;

	// ****************************************
	// Operand fields
	// ****************************************
	wire dbl;
	wire norm_mode;
	wire [4:0] src_idx;
	wire [1:0] src_kind;
	wire [4:0] dst_idx;
	wire [1:0] dst_kind;

	assign dbl = cfg_r[`FPLE_CFG_DBL];
	assign norm_mode = cfg_r[`FPLE_CFG_NORM];
	assign src_idx = cmd_r[4:0];
	assign src_kind = cmd_r[6:5];
	assign dst_idx = cmd_r[12:8];
	assign dst_kind = cmd_r[14:13];

	// ****************************************
	// Bus decode
	// ****************************************
	assign access = psel && penable;
	assign commit = access && pready;
	assign wr = commit && pwrite && !bad_addr && !bad_wr;
	assign start = wr && (paddr == `FPLE_OFF_CMD);

	always @* begin
		rd_mux = `FPLE_RST_WORD;
		bad_addr = 1'b0;
		bad_wr = 1'b0;
		case (paddr)
		`FPLE_OFF_SRC_LO: begin
			rd_mux = src_lo_r;
		end
		`FPLE_OFF_SRC_HI: begin
			rd_mux = src_hi_r;
		end
		`FPLE_OFF_CFG: begin
			rd_mux = {26'h000_0000, cfg_r};
		end
		`FPLE_OFF_CMD: begin
			rd_mux = {17'h0_0000, cmd_r};
			bad_wr = pwrite && (state_r == `FPLE_ST_EXEC);
		end
		`FPLE_OFF_RES_LO: begin
			rd_mux = res_lo_r;
			bad_wr = pwrite;
		end
		`FPLE_OFF_RES_HI: begin
			rd_mux = res_hi_r;
			bad_wr = pwrite;
		end
		`FPLE_OFF_STATUS: begin
			rd_mux = {24'h00_0000, status_r};
			bad_wr = pwrite;
		end
		`FPLE_OFF_INT_CLR: begin
			rd_mux = `FPLE_RST_WORD;
		end
		`FPLE_OFF_INT_EN: begin
			rd_mux = {24'h00_0000, int_en_r};
		end
		`FPLE_OFF_INFO: begin
			rd_mux = {16'h0000, 1'b0, dst_kind, dst_idx, 7'h00, state_r};
			bad_wr = pwrite;
		end
		default: begin
			bad_addr = 1'b1;
		end
		endcase
	end

	// ****************************************
	// APB response
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= `FPLE_RST_WORD;
			pslverr <= 1'b0;
		end else begin
			pready <= access && !pready;
			if (access && !pready) begin
				prdata <= (pwrite || bad_addr) ? `FPLE_RST_WORD : rd_mux;
				pslverr <= bad_addr || bad_wr;
			end else begin
				prdata <= `FPLE_RST_WORD;
				pslverr <= 1'b0;
			end
		end
	end

	// ****************************************
	// Datapath
	// ****************************************
	wire [63:0] src_val;
	wire [63:0] src_reg;
	wire u_zero;
	wire u_den;
	wire u_inf;
	wire u_nan;
	wire u_snan;
	wire [11:0] u_exp;
	wire [63:0] cv_res;
	wire cv_inex;
	wire cv_under;

	assign src_reg = dbl ? {src_hi_r, src_lo_r} : {32'h0000_0000, src_lo_r};
	assign src_val = (src_kind == `FPLE_KIND_FLIT) ?
		(src_idx[0] ? (dbl ? `FPLE_ONE_D : {32'h0000_0000, `FPLE_ONE_S}) : 64'h0000_0000_0000_0000) :
		src_reg;

	fple_unpack u_unpack (
		.src(src_val),
		.dbl(dbl),
		.is_zero(u_zero),
		.is_denorm(u_den),
		.is_inf(u_inf),
		.is_nan(u_nan),
		.is_snan(u_snan),
		.exp_unb(u_exp)
	);

	fple_i2f u_i2f (
		.ival(u_exp),
		.dbl(dbl),
		.res(cv_res),
		.inexact(cv_inex),
		.underflow(cv_under)
	);

	// ****************************************
	// Classification and exceptions
	// ****************************************
	wire opnd_bad;
	wire rsvd;
	wire ex_inv;
	wire ex_zdiv;
	wire ex_under;
	wire ex_inex;
	wire fault;
	wire finite;
	wire [63:0] qnan;
	wire [63:0] result;

	assign opnd_bad = (src_kind == 2'h3) ||
		((src_kind == `FPLE_KIND_FLIT) && (src_idx > 5'h01)) ||
		((src_kind == `FPLE_KIND_GREG) && dbl && src_idx[0]) ||
		(dst_kind[1]) ||
		((dst_kind == `FPLE_KIND_GREG) && dbl && dst_idx[0]);
	assign rsvd = !opnd_bad && u_den && norm_mode;
	assign finite = !u_zero && !u_inf && !u_nan;
	assign ex_inv = !opnd_bad && !rsvd && u_snan;
	assign ex_zdiv = !opnd_bad && !rsvd && u_zero;
	assign ex_under = !opnd_bad && !rsvd && finite && cv_under;
	assign ex_inex = !opnd_bad && !rsvd && finite && cv_inex;
	assign fault = opnd_bad || rsvd ||
		(ex_inv && cfg_r[`FPLE_CFG_FE_INV]) ||
		(ex_zdiv && cfg_r[`FPLE_CFG_FE_ZDIV]) ||
		(ex_under && cfg_r[`FPLE_CFG_FE_UNDER]) ||
		(ex_inex && cfg_r[`FPLE_CFG_FE_INEX]);

	assign qnan = dbl ? (src_val | (64'h0000_0000_0000_0001 << `FPLE_QBIT_D)) :
		(src_val | (64'h0000_0000_0000_0001 << `FPLE_QBIT_S));
	assign result = u_nan ? qnan :
		u_inf ? (dbl ? `FPLE_PINF_D : {32'h0000_0000, `FPLE_PINF_S}) :
		u_zero ? (dbl ? `FPLE_NINF_D : {32'h0000_0000, `FPLE_NINF_S}) :
		cv_res;

	// ****************************************
	// Sequencer
	// ****************************************
	always @* begin
		state_nxt = state_r;
		case (state_r)
		`FPLE_ST_IDLE: begin
			if (start)
				state_nxt = `FPLE_ST_EXEC;
		end
		`FPLE_ST_EXEC: begin
			state_nxt = `FPLE_ST_IDLE;
		end
		default: begin
			state_nxt = `FPLE_ST_IDLE;
		end
		endcase
	end

	// ****************************************
	// Sticky status, set wins over clear
	// ****************************************
	reg [`FPLE_ST_W-1:0] st_set;
	wire [`FPLE_ST_W-1:0] st_clr;

	assign st_clr = (wr && (paddr == `FPLE_OFF_INT_CLR)) ? pwdata[`FPLE_ST_W-1:0] : `FPLE_RST_STATUS;

	always @* begin
		st_set = `FPLE_RST_STATUS;
		if (state_r == `FPLE_ST_EXEC) begin
			st_set[`FPLE_ST_DONE] = 1'b1;
			st_set[`FPLE_ST_FAULT] = fault;
			st_set[`FPLE_ST_RSVD] = rsvd;
			st_set[`FPLE_ST_INV] = ex_inv;
			st_set[`FPLE_ST_ZDIV] = ex_zdiv;
			st_set[`FPLE_ST_UNDER] = ex_under;
			st_set[`FPLE_ST_INEX] = ex_inex;
			st_set[`FPLE_ST_OPND] = opnd_bad;
		end
		status_nxt = (status_r & ~st_clr) | st_set;
	end

	// ****************************************
	// Register writes
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_lo_r <= `FPLE_RST_WORD;
			src_hi_r <= `FPLE_RST_WORD;
			cfg_r <= `FPLE_RST_CFG;
			cmd_r <= `FPLE_RST_CMD;
			int_en_r <= `FPLE_RST_STATUS;
			res_lo_r <= `FPLE_RST_WORD;
			res_hi_r <= `FPLE_RST_WORD;
			status_r <= `FPLE_RST_STATUS;
			state_r <= `FPLE_ST_IDLE;
			irq <= 1'b0;
		end else begin
			state_r <= state_nxt;
			status_r <= status_nxt;
			irq <= |(status_r & int_en_r);
			if (wr && (paddr == `FPLE_OFF_SRC_LO))
				src_lo_r <= pwdata;
			if (wr && (paddr == `FPLE_OFF_SRC_HI))
				src_hi_r <= pwdata;
			if (wr && (paddr == `FPLE_OFF_CFG) && (state_r == `FPLE_ST_IDLE))
				cfg_r <= pwdata[`FPLE_CFG_W-1:0];
			if (start)
				cmd_r <= pwdata[`FPLE_CMD_W-1:0];
			if (wr && (paddr == `FPLE_OFF_INT_EN))
				int_en_r <= pwdata[`FPLE_ST_W-1:0];
			if ((state_r == `FPLE_ST_EXEC) && !fault) begin
				res_lo_r <= result[31:0];
				res_hi_r <= result[63:32];
			end
		end
	end
endmodule
`default_nettype wire

/* File: fple_unit_properties.sv */
// Bus and interrupt checker for the exponent unit
`timescale 1ns/1ps
`default_nettype none
`include "fple_consts.vh"

module fple_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq
);
	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic acc_end;
	assign acc_end = psel && penable && pready;
	logic cmd_wr;
	logic en_wr;
	logic clr_wr;
	assign cmd_wr = acc_end && pwrite && (paddr == `FPLE_OFF_CMD);
	assign en_wr = acc_end && pwrite && (paddr == `FPLE_OFF_INT_EN);
	assign clr_wr = acc_end && pwrite && (paddr == `FPLE_OFF_INT_CLR);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	one_wait_a: assert property (s_setup ##1 s_access |=> pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready too long");
	ready_cause_a: assert property (!(psel && penable) |=> !pready)
		else $error("pready without access");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0000_0000)
		else $error("prdata not zero");
	unmapped_err_a: assert property (acc_end && (paddr > `FPLE_OFF_INFO || paddr[1:0] != 2'h0) |-> pslverr)
		else $error("unmapped without error");
	ro_write_a: assert property (acc_end && pwrite && (paddr == `FPLE_OFF_RES_LO || paddr == `FPLE_OFF_RES_HI
		|| paddr == `FPLE_OFF_STATUS || paddr == `FPLE_OFF_INFO) |-> pslverr)
		else $error("read-only write accepted");
	read_ok_a: assert property (acc_end && !pwrite && paddr <= `FPLE_OFF_INFO && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped read refused");
	irq_rise_a: assert property ($rose(irq) |-> $past(cmd_wr, 3) || $past(en_wr, 2))
		else $error("irq rose without cause");
	irq_fall_a: assert property ($fell(irq) |-> $past(clr_wr, 2) || $past(en_wr, 2))
		else $error("irq fell without cause");
endmodule

bind fple_unit fple_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

/* File: fp_log_binary_exponent_unit_bench.sv */
// Self-checking bench for the exponent unit
`timescale 1ns/1ps
`default_nettype none
`include "fple_consts.vh"

module fp_log_binary_exponent_unit_bench;
	// ****************
	// Bench
	// ****************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire irq;
	int fail_count = 0;
	int n_checks = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic er;

	always #2.5 pclk = ~pclk;

	fple_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			$display("FAIL timeout expected end seen hang");
			test_done();
		end
	end

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_checks++;
		if (got !== ex) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("access cycles", 32'h0000_0002, n);
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, ex, rd);
	endtask

	task automatic errchk(input logic w, input logic [7:0] a);
		apb(w, a, 32'h0000_0000);
		chk("pslverr", 32'h0000_0001, {31'h0, er});
	endtask

	task automatic run(input logic [31:0] cfg, input logic [31:0] hi, input logic [31:0] lo,
		input logic [31:0] cmd, input logic [31:0] rh, input logic [31:0] rl, input logic [31:0] st);
		apb(1'b1, `FPLE_OFF_SRC_LO, lo);
		apb(1'b1, `FPLE_OFF_SRC_HI, hi);
		apb(1'b1, `FPLE_OFF_CFG, cfg);
		apb(1'b1, `FPLE_OFF_CMD, cmd);
		rdchk("res_hi", `FPLE_OFF_RES_HI, rh);
		rdchk("res_lo", `FPLE_OFF_RES_LO, rl);
		rdchk("status", `FPLE_OFF_STATUS, st);
		apb(1'b1, `FPLE_OFF_INT_CLR, 32'h0000_00FF);
		$display("test cfg %h src %h_%h cmd %h done", cfg, hi, lo, cmd);
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("cfg", `FPLE_OFF_CFG, 32'h0000_0000);
		rdchk("status", `FPLE_OFF_STATUS, 32'h0000_0000);
		rdchk("int_en", `FPLE_OFF_INT_EN, 32'h0000_0000);
		rdchk("int_clr", `FPLE_OFF_INT_CLR, 32'h0000_0000);
		errchk(1'b0, 8'h28);
		errchk(1'b0, 8'h02);
		errchk(1'b1, `FPLE_OFF_STATUS);
		errchk(1'b1, `FPLE_OFF_RES_LO);
		$display("test register map done");
		run(0, 0, 32'h4100_0000, 32'h0000_2020, 0, 32'h4040_0000, 32'h01);
		run(0, 0, 32'h3E80_0000, 32'h0000_2020, 0, 32'hC000_0000, 32'h01);
		run(0, 0, 32'h0000_0001, 32'h0000_2020, 0, 32'hC315_0000, 32'h01);
		run(2, 0, 32'h0000_0001, 32'h0000_2020, 0, 32'hC315_0000, 32'h07);
		run(0, 0, 32'hFF80_0000, 32'h0000_2020, 0, 32'h7F80_0000, 32'h01);
		run(0, 0, 32'h7F80_0001, 32'h0000_2020, 0, 32'h7FC0_0001, 32'h09);
		run(8, 0, 32'h0000_0000, 32'h0000_2020, 0, 32'h7FC0_0001, 32'h13);
		run(0, 0, 32'h8000_0000, 32'h0000_2020, 0, 32'hFF80_0000, 32'h11);
		run(4, 0, 32'h7F80_0001, 32'h0000_2020, 0, 32'hFF80_0000, 32'h0B);
		run(1, 32'h4010_0000, 0, 32'h0000_2020, 32'h4000_0000, 0, 32'h01);
		run(1, 0, 32'h0000_0001, 32'h0000_2020, 32'hC090_C800, 0, 32'h01);
		run(1, 32'h4010_0000, 0, 32'h0000_2001, 32'hC090_C800, 0, 32'h83);
		run(1, 32'h4010_0000, 0, 32'h0000_2002, 32'h4000_0000, 0, 32'h01);
		run(0, 0, 0, 32'h0000_2041, 0, 0, 32'h01);
		run(0, 0, 32'h4100_0000, 32'h0000_4020, 0, 0, 32'h83);
		rdchk("info", `FPLE_OFF_INFO, 32'h0000_4000);
		apb(1'b1, `FPLE_OFF_INT_EN, 32'h0000_0001);
		rdchk("int_en", `FPLE_OFF_INT_EN, 32'h0000_0001);
		apb(1'b1, `FPLE_OFF_CMD, 32'h0000_2020);
		rdchk("status", `FPLE_OFF_STATUS, 32'h0000_0001);
		chk("irq set", 32'h1, {31'h0, irq});
		apb(1'b1, `FPLE_OFF_INT_CLR, 32'h0000_00FF);
		repeat (2) @(posedge pclk);
		chk("irq clear", 32'h0, {31'h0, irq});
		apb(1'b1, `FPLE_OFF_INT_EN, 32'h0000_0000);
		apb(1'b1, `FPLE_OFF_CMD, 32'h0000_2020);
		rdchk("status", `FPLE_OFF_STATUS, 32'h0000_0001);
		chk("irq masked", 32'h0, {31'h0, irq});
		$display("test interrupt done");
		test_done();
	end
endmodule
`default_nettype wire
